// ===== dimr_regbank.sv
// Register bank of a sixteen-input station, served to Modbus/TCP connections.
// Assumes the protocol stack hands over one decoded register access at a time.
//
// Overview of operation
// - Writes to read-only words rejected, exception 02
// - Command must be one-hot, else error
// - Command word is write-only
// - Command bit 7 clears latched fault
// - Summary bit 0 set while any error
// - Fault bit 2 tracks supply undervoltage
// - Fault bit 3 tracks supply surge
// - Fault bit 4 flags supply overload
// - Fault bit 10 flags overtemperature
// - Inputs 1-8 low byte, 9-16 high
// - Words big-endian, one word per register
// - Byte-wide items sit in low byte
// - High byte of byte items reads zero
// - Connection requests served within 350 ms
// - Cyclic connection possible within 500 ms
// - Switch position 0F restores delivery defaults
// - Indicator code: byte digit, bit digit
// - Up to eight connections, any register
`timescale 1ns/1ns
`include "dimr_cfg.svh"
module dimr_regbank
  import dimr_pkg::*;
#(
  parameter int unsigned CONN_CYC   = `DIMR_CONN_READY_CYC,
  parameter int unsigned CYCLIC_CYC = `DIMR_CYCLIC_READY_CYC
)
(
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_req_valid,
  input  wire logic        i_req_write,
  input  wire logic [2:0]  i_req_conn,
  input  wire logic [15:0] i_req_addr,
  input  wire logic [15:0] i_req_wdata,
  input  wire logic [15:0] i_input_terminal_number,
  input  wire logic        i_sensor_supply_rail_undervolt,
  input  wire logic        i_sensor_supply_rail_surge,
  input  wire logic        i_sensor_supply_rail_overload,
  input  wire logic        i_overtemp,
  input  wire logic [3:0]  i_rotary_switch,
  output logic             o_rsp_valid,
  output logic [2:0]       o_rsp_conn,
  output logic [15:0]      o_rsp_rdata,
  output logic [7:0]       o_rsp_exception,
  output logic             o_cmd_error,
  output logic             o_factory_reset,
  output logic             o_conn_ready,
  output logic             o_cyclic_ready,
  output logic [15:0]      o_input_leds
);

  typedef struct packed {
    logic        rsp_valid;
    logic [2:0]  rsp_conn;
    logic [15:0] rsp_rdata;
    logic [7:0]  rsp_exception;
    logic        cmd_error;
    logic        overload_latch;
    logic        overtemp_latch;
    logic        factory_reset;
    logic        conn_ready;
    logic        cyclic_ready;
    logic [15:0] input_leds;
  } dimr_bank_state_type;

  dimr_bank_state_type state_q;
  dimr_bank_state_type state_d;

  logic        cmd_one_hot;
  logic        boot_conn_ready;
  logic        boot_cyclic_ready;
  logic [15:0] fault_word;
  logic        clear_cmd;

  function automatic logic dimr_is_read_only(input logic [15:0] addr);
    dimr_is_read_only = (addr == `DIMR_REG_ERROR_SUMMARY) || (addr == `DIMR_REG_FAULT_DETAIL) ||
                        (addr == `DIMR_REG_INPUT_STATES);
  endfunction

  function automatic logic dimr_is_command(input logic [15:0] addr);
    dimr_is_command = (addr == `DIMR_REG_COMMAND);
  endfunction

  dimr_onehot_chk u_dimr_onehot_chk
  (
    .i_value   (i_req_wdata),
    .o_one_hot (cmd_one_hot)
  );

  dimr_boot_timer #(
    .CONN_CYC   (CONN_CYC),
    .CYCLIC_CYC (CYCLIC_CYC)
  ) u_dimr_boot_timer (
    .i_core_clk     (i_core_clk),
    .i_rst_n        (i_rst_n),
    .o_conn_ready   (boot_conn_ready),
    .o_cyclic_ready (boot_cyclic_ready)
  );

  // Live supply levels plus latched overload and overtemperature
  always_comb
  begin
    fault_word = 16'h0000;
    fault_word[`DIMR_DIAG_UNDERVOLT_BIT] = i_sensor_supply_rail_undervolt;
    fault_word[`DIMR_DIAG_SURGE_BIT]     = i_sensor_supply_rail_surge;
    fault_word[`DIMR_DIAG_OVERLOAD_BIT]  = state_q.overload_latch;
    fault_word[`DIMR_DIAG_OVERTEMP_BIT]  = state_q.overtemp_latch;
  end

  assign clear_cmd = i_req_valid && i_req_write && dimr_is_command(i_req_addr) &&
                     state_q.conn_ready && cmd_one_hot && i_req_wdata[`DIMR_CMD_CLEAR_BIT];

  always_comb
  begin
    state_d = state_q;
    state_d.rsp_valid     = 1'b0;
    state_d.conn_ready    = boot_conn_ready;
    state_d.cyclic_ready  = boot_cyclic_ready;
    state_d.factory_reset = (i_rotary_switch == `DIMR_FACTORY_SWITCH);
    // Byte digit selects the half, bit digit the lamp
    state_d.input_leds    = i_input_terminal_number;

    // Clear first, then set: an event in the clearing cycle survives
    if (clear_cmd)
    begin
      state_d.overload_latch = 1'b0;
      state_d.overtemp_latch = 1'b0;
      state_d.cmd_error      = 1'b0;
    end
    if (i_sensor_supply_rail_overload)
      state_d.overload_latch = 1'b1;
    if (i_overtemp)
      state_d.overtemp_latch = 1'b1;

    // Any connection may reach any register; one access per cycle
    if (i_req_valid && state_q.conn_ready)
    begin
      state_d.rsp_valid     = 1'b1;
      state_d.rsp_conn      = i_req_conn;
      state_d.rsp_rdata     = 16'h0000;
      state_d.rsp_exception = `DIMR_EXC_NONE;
      if (i_req_write)
      begin
        if (dimr_is_command(i_req_addr))
        begin
          if (!cmd_one_hot)
          begin
            state_d.cmd_error     = 1'b1;
            state_d.rsp_exception = `DIMR_EXC_ILLEGAL_VALUE;
          end
        end
        else if (dimr_is_read_only(i_req_addr))
          state_d.rsp_exception = `DIMR_EXC_ILLEGAL_ADDR;
        else
          state_d.rsp_exception = `DIMR_EXC_ILLEGAL_ADDR;
      end
      else
      begin
        unique case (i_req_addr)
          `DIMR_REG_ERROR_SUMMARY:
            state_d.rsp_rdata = {15'h0000, (|fault_word) | state_q.cmd_error};
          `DIMR_REG_FAULT_DETAIL:
            state_d.rsp_rdata = fault_word;
          `DIMR_REG_INPUT_STATES:
            // Bit i of the word is input i+1; big-endian on the wire
            state_d.rsp_rdata = i_input_terminal_number;
          default:
            // Command word is never read back
            state_d.rsp_exception = `DIMR_EXC_ILLEGAL_ADDR;
        endcase
      end
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      state_q.rsp_valid      <= 1'b0;
      state_q.rsp_conn       <= 3'h0;
      state_q.rsp_rdata      <= 16'h0000;
      state_q.rsp_exception  <= 8'h00;
      state_q.cmd_error      <= 1'b0;
      state_q.overload_latch <= 1'b0;
      state_q.overtemp_latch <= 1'b0;
      state_q.factory_reset  <= 1'b0;
      state_q.conn_ready     <= 1'b0;
      state_q.cyclic_ready   <= 1'b0;
      state_q.input_leds     <= 16'h0000;
    end
    else
      state_q <= state_d;
  end

  // Whole-word registers; no byte-wide items exist here, so hold trivially
  assign o_rsp_valid     = state_q.rsp_valid;
  assign o_rsp_conn      = state_q.rsp_conn;
  assign o_rsp_rdata     = state_q.rsp_rdata;
  assign o_rsp_exception = state_q.rsp_exception;
  assign o_cmd_error     = state_q.cmd_error;
  assign o_factory_reset = state_q.factory_reset;
  assign o_conn_ready    = state_q.conn_ready;
  assign o_cyclic_ready  = state_q.cyclic_ready;
  assign o_input_leds    = state_q.input_leds;

endmodule

// ===== dimr_cfg.svh
// Constants of the digital input register bank: offsets, field positions, timing.
// Assumes a 125 MHz core clock and register numbers as seen by the request port.
`ifndef DIMR_CFG_SVH
`define DIMR_CFG_SVH

`define DIMR_REG_COMMAND        16'h07D6
`define DIMR_REG_ERROR_SUMMARY  16'h1F3C
`define DIMR_REG_FAULT_DETAIL   16'h1F3D
`define DIMR_REG_INPUT_STATES   16'h1F40

`define DIMR_CMD_CLEAR_BIT      7
`define DIMR_SUM_ERROR_BIT      0
`define DIMR_DIAG_UNDERVOLT_BIT 2
`define DIMR_DIAG_SURGE_BIT     3
`define DIMR_DIAG_OVERLOAD_BIT  4
`define DIMR_DIAG_OVERTEMP_BIT  10

`define DIMR_EXC_NONE           8'h00
`define DIMR_EXC_ILLEGAL_FUNC   8'h01
`define DIMR_EXC_ILLEGAL_ADDR   8'h02
`define DIMR_EXC_ILLEGAL_VALUE  8'h03

`define DIMR_FACTORY_SWITCH     4'hF
`define DIMR_MAX_CONN           8

`define DIMR_CLK_MHZ            125
`define DIMR_CONN_READY_MS      350
`define DIMR_CYCLIC_READY_MS    500
// Cycles per millisecond is MHz times 1000; kept in that order so no product leaves 32 bits
`define DIMR_CONN_READY_CYC     (`DIMR_CONN_READY_MS * `DIMR_CLK_MHZ * 1000)
`define DIMR_CYCLIC_READY_CYC   (`DIMR_CYCLIC_READY_MS * `DIMR_CLK_MHZ * 1000)

`endif

// ===== dimr_pkg.sv
// Types of the digital input register bank.
// Assumes dimr_cfg.svh supplies all numeric constants.
package dimr_pkg;

  typedef enum logic [1:0] {
    DIMR_OP_NONE,
    DIMR_OP_READ,
    DIMR_OP_WRITE
  } dimr_op_type;

  typedef enum logic [1:0] {
    DIMR_BOOT,
    DIMR_CONN_OK,
    DIMR_CYCLIC_OK
  } dimr_boot_type;

endpackage

// ===== dimr_onehot_chk.sv
// One-hot check of a written command word.
// Assumes a purely combinational use inside the register bank.
`timescale 1ns/1ns
module dimr_onehot_chk
(
  input  wire logic [15:0] i_value,
  output logic             o_one_hot
);

  logic [4:0] count;

  always_comb
  begin
    count = 5'h00;
    for (int i = 0; i < 16; i++)
    begin
      count = count + {4'h0, i_value[i]};
    end
    o_one_hot = (count == 5'h01);
  end

endmodule

// ===== dimr_boot_timer.sv
// Start-up timer: marks when connection requests and cyclic links may begin.
// Assumes reset is released when power is good.
`timescale 1ns/1ns
`include "dimr_cfg.svh"
module dimr_boot_timer
  import dimr_pkg::*;
#(
  parameter int unsigned CONN_CYC   = `DIMR_CONN_READY_CYC,
  parameter int unsigned CYCLIC_CYC = `DIMR_CYCLIC_READY_CYC
)
(
  input  wire logic i_core_clk,
  input  wire logic i_rst_n,
  output logic      o_conn_ready,
  output logic      o_cyclic_ready
);

  typedef struct packed {
    dimr_boot_type phase;
    logic [31:0]   count;
  } dimr_boot_state_type;

  dimr_boot_state_type state_q;
  dimr_boot_state_type state_d;

  always_comb
  begin
    state_d = state_q;
    unique case (state_q.phase)
      DIMR_BOOT:
      begin
        state_d.count = state_q.count + 32'h1;
        if (state_q.count >= CONN_CYC - 1)
          state_d.phase = DIMR_CONN_OK;
      end
      DIMR_CONN_OK:
      begin
        state_d.count = state_q.count + 32'h1;
        if (state_q.count >= CYCLIC_CYC - 1)
          state_d.phase = DIMR_CYCLIC_OK;
      end
      DIMR_CYCLIC_OK:
        state_d.count = state_q.count;
      default:
        state_d.phase = DIMR_BOOT;
    endcase
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      state_q.phase <= DIMR_BOOT;
      state_q.count <= 32'h0;
    end
    else
      state_q <= state_d;
  end

  assign o_conn_ready   = (state_q.phase != DIMR_BOOT);
  assign o_cyclic_ready = (state_q.phase == DIMR_CYCLIC_OK);

endmodule

// ===== dimr_regbank_sva.sv
// Checker of the register bank answer port.
// Assumes one clock domain and binding to every instance of dimr_regbank.
`timescale 1ns/1ns
module dimr_regbank_sva
(
  input wire logic        i_core_clk,
  input wire logic        i_rst_n,
  input wire logic        i_req_valid,
  input wire logic        i_req_write,
  input wire logic [15:0] i_req_addr,
  input wire logic [15:0] i_req_wdata,
  input wire logic [15:0] i_input_terminal_number,
  input wire logic [3:0]  i_rotary_switch,
  input wire logic        o_rsp_valid,
  input wire logic [15:0] o_rsp_rdata,
  input wire logic [7:0]  o_rsp_exception,
  input wire logic        o_cmd_error,
  input wire logic        o_factory_reset,
  input wire logic        o_conn_ready
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  logic tk;
  logic rd_t;
  logic wr_t;
  assign tk = i_req_valid && o_conn_ready;
  assign rd_t = tk && !i_req_write;
  assign wr_t = tk && i_req_write;
  AST_RSP_TIME: assert property (tk |=> o_rsp_valid)
    else $error("no answer");
  AST_NO_SPUR: assert property (!tk |=> !o_rsp_valid)
    else $error("stray answer");
  AST_RO_WR: assert property (wr_t && i_req_addr[15:8] == 8'h1F |=> o_rsp_exception == 8'h02)
    else $error("read-only write taken");
  AST_CMD_RD: assert property (rd_t && i_req_addr == 16'h07D6
    |=> {o_rsp_exception, o_rsp_rdata} == 24'h020000) else $error("command readable");
  AST_CMD_MULTI: assert property (wr_t && i_req_addr == 16'h07D6 && $countones(i_req_wdata) > 1
    |=> o_rsp_exception == 8'h03 && o_cmd_error) else $error("bad command taken");
  AST_INPUTS: assert property (rd_t && i_req_addr == 16'h1F40
    |=> o_rsp_rdata == $past(i_input_terminal_number)) else $error("input word wrong");
  AST_CLEAR: assert property (wr_t && i_req_addr == 16'h07D6 && i_req_wdata == 16'h0080
    |=> o_rsp_exception == 8'h00 && !o_cmd_error) else $error("clear failed");
  AST_FACTORY: assert property ((i_rotary_switch == 4'hF) [*2] |-> o_factory_reset)
    else $error("defaults not restored");
  cover property (wr_t ##1 o_rsp_exception == 8'h02);
  cover property (wr_t ##1 o_rsp_exception == 8'h03);
  cover property (rd_t && i_req_addr == 16'h1F40);
endmodule

bind dimr_regbank dimr_regbank_sva u_dimr_regbank_sva (.*);

// ===== dimr_client.sv
// Client model: issues one register access and collects its answer.
// Assumes the bank registers its answer on the taking edge, readable 1 ns after it.
`timescale 1ns/1ns
module dimr_client
(
  input  wire logic        i_core_clk,
  input  wire logic        i_rsp_valid,
  input  wire logic [2:0]  i_rsp_conn,
  input  wire logic [15:0] i_rsp_rdata,
  input  wire logic [7:0]  i_rsp_exception,
  output logic             o_req_valid,
  output logic             o_req_write,
  output logic [2:0]       o_req_conn,
  output logic [15:0]      o_req_addr,
  output logic [15:0]      o_req_wdata
);
  initial
  begin
    {o_req_valid, o_req_write, o_req_conn, o_req_addr, o_req_wdata} = 37'h0;
  end
  task automatic access(input logic w, input logic [2:0] c, input logic [15:0] a, input logic [15:0] d,
    output logic got, output logic [2:0] rc, output logic [15:0] rd, output logic [7:0] ex);
    @(posedge i_core_clk);
    #1;
    {o_req_valid, o_req_write, o_req_conn, o_req_addr, o_req_wdata} = {1'b1, w, c, a, d};
    @(posedge i_core_clk);
    #1;
    // Released address and data lines carry no stale value
    {o_req_valid, o_req_addr, o_req_wdata} = {1'b0, ~a, ~d};
    {got, rc, rd, ex} = {i_rsp_valid, i_rsp_conn, i_rsp_rdata, i_rsp_exception};
  endtask
endmodule

// ===== dimr_regbank_tb.sv
// Self-checking bench of the register bank with a client model.
// Assumes shortened start-up counts of 10 and 20 cycles.
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH %s %0h %0h", n, e, g); end end
module dimr_regbank_tb;
  logic        clk = 0, rst_n = 0, vld, wr, got, uv = 0, sg = 0, ol = 0, ot = 0, err, fr, rdy, cyc, rv;
  logic [2:0]  cn, rc, rcn;
  logic [3:0]  sw = 0;
  logic [7:0]  ex, rex;
  logic [15:0] ad, wd, ins = 0, rd, rrd, leds, d;
  logic [15:0] ro [4] = '{16'h1F3C, 16'h1F3D, 16'h1F40, 16'h1234};
  logic [31:0] s = 67378;
  int          fails = 0, checks_done = 0;
  dimr_regbank #(.CONN_CYC(10), .CYCLIC_CYC(20)) u_dimr_regbank (.i_core_clk(clk), .i_rst_n(rst_n),
    .i_req_valid(vld), .i_req_write(wr), .i_req_conn(cn), .i_req_addr(ad), .i_req_wdata(wd),
    .i_input_terminal_number(ins), .i_sensor_supply_rail_undervolt(uv), .i_sensor_supply_rail_surge(sg),
    .i_sensor_supply_rail_overload(ol), .i_overtemp(ot), .i_rotary_switch(sw), .o_rsp_valid(rv),
    .o_rsp_conn(rcn), .o_rsp_rdata(rrd), .o_rsp_exception(rex), .o_cmd_error(err), .o_factory_reset(fr),
    .o_conn_ready(rdy), .o_cyclic_ready(cyc), .o_input_leds(leds));
  dimr_client u_dimr_client (.i_core_clk(clk), .i_rsp_valid(rv), .i_rsp_conn(rcn), .i_rsp_rdata(rrd),
    .i_rsp_exception(rex), .o_req_valid(vld), .o_req_write(wr), .o_req_conn(cn), .o_req_addr(ad),
    .o_req_wdata(wd));
  function logic [15:0] xs();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s[15:0];
  endfunction
  function automatic logic [15:0] fexp(logic u, logic g, logic o, logic t);
    return {5'h00, t, 5'h00, o, g, u, 2'h0};
  endfunction
  task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] dd);
    logic [2:0]  c;
    logic [15:0] r;
    r = xs();
    c = r[2:0];
    u_dimr_client.access(w, c, a, dd, got, rc, rd, ex);
    `CHK("rsp", {1'b1, c}, {got, rc})
  endtask
  task end_sim();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    forever #4 clk = ~clk;
  end
  initial
  begin
    #20000;
    fails++;
    end_sim();
  end
  initial
  begin
    repeat (10) @(posedge clk);
    #1 rst_n = 1;
    u_dimr_client.access(1'b0, 3'h0, 16'h1F40, 16'h0000, got, rc, rd, ex);
    `CHK("early", 2'b00, {got, cyc})
    repeat (12) @(posedge clk);
    #1;
    `CHK("conn_ready", 1'b1, rdy)
    for (int i = 0; i < 8; i++)
    begin
      ins = (i == 0) ? 16'h8001 : xs();
      acc(1'b0, 16'h1F40, 16'h0000);
      `CHK("inputs", {8'h00, ins}, {ex, rd})
      `CHK("leds", ins, leds)
    end
    foreach (ro[i])
    begin
      acc(1'b1, ro[i], 16'h0080);
      `CHK("ro_wr", 8'h02, ex)
    end
    acc(1'b0, 16'h1F40, 16'h0000);
    `CHK("ro_kept", {8'h00, ins}, {ex, rd})
    acc(1'b0, 16'h07D6, 16'h0000);
    `CHK("cmd_rd", 24'h020000, {ex, rd})
    {uv, sg} = 2'b11;
    acc(1'b0, 16'h1F3D, 16'h0000);
    `CHK("diag", fexp(1'b1, 1'b1, 1'b0, 1'b0), rd)
    acc(1'b0, 16'h1F3C, 16'h0000);
    `CHK("sum", 16'h0001, rd)
    {uv, sg, ol, ot} = 4'b0011;
    repeat (2) @(posedge clk);
    #1 {ol, ot} = 2'b00;
    acc(1'b0, 16'h1F3D, 16'h0000);
    `CHK("latched", fexp(1'b0, 1'b0, 1'b1, 1'b1), rd)
    acc(1'b1, 16'h07D6, 16'h0001);
    `CHK("rsvd_cmd", 8'h00, ex)
    acc(1'b0, 16'h1F3D, 16'h0000);
    `CHK("rsvd_kept", fexp(1'b0, 1'b0, 1'b1, 1'b1), rd)
    acc(1'b1, 16'h07D6, 16'h0080);
    acc(1'b0, 16'h1F3D, 16'h0000);
    `CHK("cleared", 16'h0000, rd)
    uv = 1'b1;
    acc(1'b1, 16'h07D6, 16'h0080);
    acc(1'b0, 16'h1F3C, 16'h0000);
    `CHK("sum_held", 16'h0001, rd)
    uv = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      d = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : (xs() | 16'h0300);
      acc(1'b1, 16'h07D6, d);
      `CHK("multi", 9'h007, {ex, err})
    end
    acc(1'b0, 16'h1F3C, 16'h0000);
    `CHK("sum_cmd", 16'h0001, rd)
    acc(1'b1, 16'h07D6, 16'h0080);
    acc(1'b0, 16'h1F3C, 16'h0000);
    `CHK("sum_clr", 17'h00000, {err, rd})
    sw = 4'hF;
    repeat (2) @(posedge clk);
    #1;
    `CHK("factory", 2'b11, {fr, cyc})
    sw = 4'hE;
    repeat (2) @(posedge clk);
    #1;
    `CHK("factory_off", 1'b0, fr)
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    `CHK("rst_out", 4'h0, {rdy, cyc, err, fr})
    u_dimr_client.access(1'b0, 3'h0, 16'h1F40, 16'h0000, got, rc, rd, ex);
    `CHK("rst_early", 1'b0, got)
    end_sim();
  end
endmodule
